// ---- hsi_pkg.sv ----
// constants and types for the humidity sensor command port
package hsi_pkg;
    localparam int unsigned CLK_MHZ    = 250;
    localparam int unsigned POR_MS     = 20;
    localparam int unsigned POR_CYC    = POR_MS * 1000 * CLK_MHZ;
    localparam int unsigned INIT_US    = 10;
    localparam int unsigned INIT_CYC   = INIT_US * CLK_MHZ;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned BYTE_W     = 8;

    localparam logic [6:0] DEV_ADDR  = 7'h38;
    localparam logic [7:0] CMD_INIT  = 8'hbe;
    localparam logic [7:0] CMD_TRIG  = 8'hac;
    localparam logic [7:0] INIT_P0   = 8'h08;
    localparam logic [7:0] TRIG_P0   = 8'h33;
    localparam logic [7:0] PARAM_P1  = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [1:0] WR_CMD    = 2'h0;
    localparam logic [1:0] WR_P0     = 2'h1;
    localparam logic [1:0] WR_P1     = 2'h2;
    localparam logic [1:0] WR_DONE   = 2'h3;
    localparam logic [2:0] RES_BYTES = 3'h5;
    localparam logic [2:0] RD_BYTES  = 3'h6;

    localparam int unsigned ST_BUSY  = 7;
    localparam int unsigned ST_MODE  = 5;
    localparam int unsigned ST_MEM   = 4;
    localparam int unsigned ST_CAL   = 3;
    localparam logic [2:0]  ST_RSVD  = 3'h0;

    typedef enum logic [1:0] {
        HSI_NORMAL = 2'b00,
        HSI_CYCLIC = 2'b01,
        HSI_CMD    = 2'b10
    } hsi_mode_t;

    typedef enum logic [1:0] {
        M_SLEEP   = 2'b00,
        M_INIT    = 2'b01,
        M_COLLECT = 2'b10
    } hsi_meas_t;

    typedef enum logic [1:0] {
        L_ADDR  = 2'b00,
        L_WRITE = 2'b01,
        L_READ  = 2'b10,
        L_SKIP  = 2'b11
    } hsi_link_t;
endpackage

// ---- hsi_cmd_port.sv ----
// humidity sensor command port: serial target, measurement control, result fifo
`timescale 1ns/1ps
// Operation
// - settle into sleep within 20 ms
// - stay idle until a command arrives
// - data fall while clock high starts
// - data rise while clock high stops
// - bus busy from start until stop
// - first byte: address 0x38 plus direction
// - acknowledge accepted byte after eighth fall
// - command 0xbe runs initialization
// - command 0xac starts a measurement
// - status bit 7 shows busy
// - status bit 4 shows memory check failure
// - status bit 3 shows calibrated
// - host polls busy, then reads six bytes

module hsi_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    // depth must be a power of two; pointers wrap naturally
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          push;
    logic          pop;

    assign in_ready_o  = count_reg != (AW+1)'(DEPTH);
    assign out_valid_o = count_reg != '0;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // hsi_fifo

////////////////////////////////////////////////////////////////////////////////

module hsi_cmd_port #(
    parameter int unsigned POR_CYC    = hsi_pkg::POR_CYC,
    parameter int unsigned INIT_CYC   = hsi_pkg::INIT_CYC,
    parameter int unsigned FIFO_DEPTH = hsi_pkg::FIFO_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       link_clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            conv_start_o,
    input  wire logic       res_valid_i,
    output logic            res_ready_o,
    input  wire logic [7:0] res_data_i,
    input  wire logic       mem_fail_i,
    input  wire logic       cal_valid_i,
    output logic [7:0]      status_o
);
    localparam int unsigned PW = $clog2(POR_CYC + 1);
    localparam int unsigned IW = $clog2(INIT_CYC + 1);

    logic [1:0]          scl_sync_reg;
    logic [1:0]          sda_sync_reg;
    logic                scl_q_reg;
    logic                sda_q_reg;
    logic                start_det;
    logic                stop_det;
    logic [PW-1:0]       por_cnt_reg;
    logic                awake_reg;
    logic                bus_free_reg;
    logic                link_hold_reg;
    logic                link_rst_b;
    logic [1:0]          cmd_sync_reg;
    logic                cmd_q_reg;
    logic                cmd_evt;
    logic                init_ok;
    logic                trig_ok;
    logic                init_go;
    logic                trig_go;
    hsi_pkg::hsi_meas_t  meas_reg;
    logic [IW-1:0]       init_cnt_reg;
    logic [2:0]          col_idx_reg;
    logic                conv_start_reg;
    logic                cal_reg;
    hsi_pkg::hsi_mode_t  mode;
    logic [7:0]          status_live;
    logic [7:0]          status_reg;
    logic [7:0]          stat_bank_reg;
    logic [7:0]          res_bank_reg [hsi_pkg::RES_BYTES];
    logic                fifo_valid;
    logic                fifo_ready;
    logic [7:0]          fifo_data;
    logic                pop;
    hsi_pkg::hsi_link_t  lstate_reg;
    logic [3:0]          bit_cnt_reg;
    logic [6:0]          shift_reg;
    logic [7:0]          byte_in;
    logic                ack_ok_reg;
    logic [1:0]          wr_idx_reg;
    logic [2:0]          rd_idx_reg;
    logic [7:0]          rd_byte_reg;
    logic [7:0]          rd_pick;
    logic [7:0]          cmd_reg;
    logic [7:0]          par0_reg;
    logic [7:0]          par1_reg;
    logic                cmd_tgl_reg;
    logic                drive_low_reg;

    ////////////////////////////////////////////////////////////////////////////
    // bus condition watch on the system clock

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_q_reg    <= 1'b1;
            sda_q_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_q_reg    <= scl_sync_reg[1];
            sda_q_reg    <= sda_sync_reg[1];
        end
    end

    assign start_det = scl_sync_reg[1] & scl_q_reg & sda_q_reg & ~sda_sync_reg[1];
    assign stop_det  = scl_sync_reg[1] & scl_q_reg & ~sda_q_reg & sda_sync_reg[1];

    // power-up settle; the serial clock is never driven, so it stays high
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            por_cnt_reg <= '0;
            awake_reg   <= 1'b0;
        end else if (!awake_reg) begin
            if (por_cnt_reg == PW'(POR_CYC - 1)) begin
                awake_reg <= 1'b1;
            end else begin
                por_cnt_reg <= por_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_free_reg <= 1'b1;
        end else if (stop_det) begin
            bus_free_reg <= 1'b1;
        end else if (start_det) begin
            bus_free_reg <= 1'b0;
        end
    end

    // link logic released only once the clock is low after a start, so the
    // reset edge never races a serial clock edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_hold_reg <= 1'b1;
        end else if (stop_det || start_det || !awake_reg) begin
            link_hold_reg <= 1'b1;
        end else if (!bus_free_reg && !scl_sync_reg[1]) begin
            link_hold_reg <= 1'b0;
        end
    end

    assign link_rst_b = ~link_hold_reg;

    ////////////////////////////////////////////////////////////////////////////
    // command execution and measurement control

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_sync_reg <= 2'h0;
            cmd_q_reg    <= 1'b0;
        end else begin
            cmd_sync_reg <= {cmd_sync_reg[0], cmd_tgl_reg};
            cmd_q_reg    <= cmd_sync_reg[1];
        end
    end

    assign cmd_evt = cmd_sync_reg[1] ^ cmd_q_reg;
    assign init_ok = (cmd_reg == hsi_pkg::CMD_INIT) && (par0_reg == hsi_pkg::INIT_P0)
                     && (par1_reg == hsi_pkg::PARAM_P1);
    assign trig_ok = (cmd_reg == hsi_pkg::CMD_TRIG) && (par0_reg == hsi_pkg::TRIG_P0)
                     && (par1_reg == hsi_pkg::PARAM_P1);
    // commands during init or a conversion are dropped to protect it
    assign init_go = cmd_evt && awake_reg && (meas_reg == hsi_pkg::M_SLEEP) && init_ok;
    assign trig_go = cmd_evt && awake_reg && (meas_reg == hsi_pkg::M_SLEEP) && trig_ok;
    // results are only taken while no frame runs, keeping the read bank still
    assign fifo_ready = (meas_reg == hsi_pkg::M_COLLECT) && link_hold_reg;
    assign pop        = fifo_valid & fifo_ready;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meas_reg       <= hsi_pkg::M_SLEEP;
            init_cnt_reg   <= '0;
            col_idx_reg    <= '0;
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= trig_go;
            case (meas_reg)
                hsi_pkg::M_SLEEP: begin
                    if (init_go) begin
                        meas_reg     <= hsi_pkg::M_INIT;
                        init_cnt_reg <= IW'(INIT_CYC - 1);
                    end else if (trig_go) begin
                        meas_reg    <= hsi_pkg::M_COLLECT;
                        col_idx_reg <= '0;
                    end
                end
                hsi_pkg::M_INIT: begin
                    if (init_cnt_reg == '0) begin
                        meas_reg <= hsi_pkg::M_SLEEP;
                    end else begin
                        init_cnt_reg <= init_cnt_reg - 1'b1;
                    end
                end
                hsi_pkg::M_COLLECT: begin
                    if (pop) begin
                        col_idx_reg <= col_idx_reg + 1'b1;
                        if (col_idx_reg == hsi_pkg::RES_BYTES - 3'h1) begin
                            meas_reg <= hsi_pkg::M_SLEEP;
                        end
                    end
                end
                default: begin
                    meas_reg <= hsi_pkg::M_SLEEP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < hsi_pkg::RES_BYTES; i++) begin
                res_bank_reg[i] <= '0;
            end
        end else if (pop) begin
            res_bank_reg[col_idx_reg] <= fifo_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cal_reg <= 1'b0;
        end else if (!awake_reg && por_cnt_reg == PW'(POR_CYC - 1)) begin
            cal_reg <= cal_valid_i;
        end else if (meas_reg == hsi_pkg::M_INIT && init_cnt_reg == '0) begin
            cal_reg <= 1'b1;
        end
    end

    assign mode = (meas_reg == hsi_pkg::M_INIT) ? hsi_pkg::HSI_CMD : hsi_pkg::HSI_NORMAL;

    always_comb begin
        status_live                       = '0;
        status_live[hsi_pkg::ST_BUSY]     = meas_reg == hsi_pkg::M_COLLECT;
        status_live[hsi_pkg::ST_MODE +: 2] = mode;
        status_live[hsi_pkg::ST_MEM]      = mem_fail_i;
        status_live[hsi_pkg::ST_CAL]      = cal_reg;
        status_live[2:0]                  = hsi_pkg::ST_RSVD;
    end

    // the bank is frozen while a frame runs; the link reads it as static
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_reg    <= '0;
            stat_bank_reg <= '0;
        end else begin
            status_reg <= status_live;
            if (link_hold_reg) begin
                stat_bank_reg <= status_live;
            end
        end
    end

    assign status_o     = status_reg;
    assign conv_start_o = conv_start_reg;

    hsi_fifo #(
        .W     (hsi_pkg::BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_res_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (res_valid_i),
        .in_ready_o  (res_ready_o),
        .in_data_i   (res_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready),
        .out_data_o  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link domain: bits sampled on rising serial clock, driven on falling

    assign byte_in = {shift_reg, sda_i};
    assign rd_pick = (rd_idx_reg == 3'h0) ? stat_bank_reg :
                     (rd_idx_reg < hsi_pkg::RD_BYTES) ? res_bank_reg[rd_idx_reg - 3'h1] :
                     hsi_pkg::IDLE_BYTE;

    always_ff @(posedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            lstate_reg  <= hsi_pkg::L_ADDR;
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
            ack_ok_reg  <= 1'b0;
            wr_idx_reg  <= hsi_pkg::WR_CMD;
            rd_idx_reg  <= '0;
            rd_byte_reg <= hsi_pkg::IDLE_BYTE;
        end else if (bit_cnt_reg == hsi_pkg::BIT_ACK) begin
            bit_cnt_reg <= '0;
            ack_ok_reg  <= 1'b0;
            if (lstate_reg == hsi_pkg::L_READ) begin
                if (!sda_i) begin
                    rd_byte_reg <= rd_pick;
                    if (rd_idx_reg != hsi_pkg::RD_BYTES) begin
                        rd_idx_reg <= rd_idx_reg + 3'h1;
                    end
                end else begin
                    lstate_reg <= hsi_pkg::L_SKIP;
                end
            end
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= byte_in[6:0];
            if (lstate_reg == hsi_pkg::L_READ) begin
                rd_byte_reg <= {rd_byte_reg[6:0], 1'b1};
            end
            if (bit_cnt_reg == hsi_pkg::BIT_LAST) begin
                case (lstate_reg)
                    hsi_pkg::L_ADDR: begin
                        if (byte_in[7:1] == hsi_pkg::DEV_ADDR) begin
                            ack_ok_reg <= 1'b1;
                            lstate_reg <= byte_in[0] ? hsi_pkg::L_READ : hsi_pkg::L_WRITE;
                        end else begin
                            lstate_reg <= hsi_pkg::L_SKIP;
                        end
                    end
                    hsi_pkg::L_WRITE: begin
                        ack_ok_reg <= 1'b1;
                        if (wr_idx_reg != hsi_pkg::WR_DONE) begin
                            wr_idx_reg <= wr_idx_reg + 2'h1;
                        end
                    end
                    default: begin
                        ack_ok_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // command bytes survive the frame; the toggle hands them to the system clock
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_reg     <= '0;
            par0_reg    <= '0;
            par1_reg    <= '0;
            cmd_tgl_reg <= 1'b0;
        end else if (link_rst_b && lstate_reg == hsi_pkg::L_WRITE
                     && bit_cnt_reg == hsi_pkg::BIT_LAST) begin
            case (wr_idx_reg)
                hsi_pkg::WR_CMD: cmd_reg <= byte_in;
                hsi_pkg::WR_P0:  par0_reg <= byte_in;
                hsi_pkg::WR_P1: begin
                    par1_reg    <= byte_in;
                    cmd_tgl_reg <= ~cmd_tgl_reg;
                end
                default: begin
                    cmd_tgl_reg <= cmd_tgl_reg;
                end
            endcase
        end
    end

    always_ff @(negedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            drive_low_reg <= 1'b0;
        end else if (bit_cnt_reg == hsi_pkg::BIT_ACK) begin
            drive_low_reg <= ack_ok_reg;
        end else begin
            drive_low_reg <= (lstate_reg == hsi_pkg::L_READ) & ~rd_byte_reg[7];
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_low_reg;

    ////////////////////////////////////////////////////////////////////////////

    AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!awake_reg && por_cnt_reg == PW'(POR_CYC - 1)) |=> awake_reg && link_hold_reg)
        else $error("not asleep and ready after power-up count");
    AST_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (meas_reg == hsi_pkg::M_SLEEP && !cmd_evt) |=> meas_reg == hsi_pkg::M_SLEEP)
        else $error("left sleep without a command");
    AST_START: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        start_det |=> !bus_free_reg && link_hold_reg)
        else $error("start not taken as bus busy");
    AST_STOP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        stop_det |=> bus_free_reg && link_hold_reg ##1 !sda_oe_o)
        else $error("stop did not free the bus");
    AST_ADDR: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (lstate_reg == hsi_pkg::L_ADDR && bit_cnt_reg == hsi_pkg::BIT_LAST
         && byte_in[7:1] != hsi_pkg::DEV_ADDR) |=> lstate_reg == hsi_pkg::L_SKIP && !ack_ok_reg)
        else $error("foreign address accepted");
    AST_ACK: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (bit_cnt_reg == hsi_pkg::BIT_ACK && ack_ok_reg) |-> sda_oe_o)
        else $error("accepted byte not acknowledged");
    AST_INIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        init_go |=> meas_reg == hsi_pkg::M_INIT ##1 status_o[hsi_pkg::ST_MODE +: 2] == hsi_pkg::HSI_CMD)
        else $error("init command not run");
    AST_CAL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (meas_reg == hsi_pkg::M_INIT && init_cnt_reg == '0) |=> ##1 status_o[hsi_pkg::ST_CAL])
        else $error("calibrated flag not set by init");
    AST_TRIG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        trig_go |=> conv_start_o ##1 status_o[hsi_pkg::ST_BUSY])
        else $error("trigger did not start a measurement");
    AST_BUSY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ##1 status_o[hsi_pkg::ST_BUSY] == $past(meas_reg == hsi_pkg::M_COLLECT))
        else $error("busy flag does not follow measurement");
    AST_MEM: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ##1 (!$past(rst_b_i) || status_o[hsi_pkg::ST_MEM] == $past(mem_fail_i)))
        else $error("memory check flag wrong");
    AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        status_o[2:0] == 3'h0 && stat_bank_reg[2:0] == 3'h0)
        else $error("reserved status bits not zero");
    AST_GUARD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (meas_reg == hsi_pkg::M_COLLECT && cmd_evt) |=> !conv_start_o)
        else $error("command disturbed running measurement");

    COV_INIT: cover property (@(posedge clk_i) disable iff (!rst_b_i) init_go);
    COV_MEAS: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        meas_reg == hsi_pkg::M_COLLECT ##1 meas_reg == hsi_pkg::M_SLEEP);
    COV_READ: cover property (@(posedge link_clk_i) disable iff (!link_rst_b)
        rd_idx_reg == hsi_pkg::RD_BYTES);
endmodule // hsi_cmd_port

// ---- hsi_host_model.sv ----
// behavioural bus controller for the humidity sensor command port
`timescale 1ns/1ps
module hsi_host_model (
    output logic      scl_o,
    output logic      sda_oe_o,
    input  wire logic sda_i
);
    // clock stands high outside frames, 64 ns bit time
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic bit_out(input logic b);
        sda_oe_o = ~b;
        #16 scl_o = 1'b1;
        #32 scl_o = 1'b0;
        #16;
    endtask
    // sample mid-high, well clear of the target's falling-edge update
    task automatic bit_in(output logic b);
        sda_oe_o = 1'b0;
        #16 scl_o = 1'b1;
        #16 b = sda_i;
        #16 scl_o = 1'b0;
        #16;
    endtask
    task automatic start();
        // 1 ns skew keeps pin edges off the system clock edges
        #1 sda_oe_o = 1'b1;
        #16 scl_o = 1'b0;
        #16;
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        #16 scl_o = 1'b1;
        #16 sda_oe_o = 1'b0;
        #47;
    endtask
    task automatic put(input logic [7:0] v, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(a);
        ack = ~a;
    endtask
    task automatic get(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_in(v[i]);
        bit_out(last);
    endtask
endmodule // hsi_host_model

// ---- hsi_cmd_port_tb_top.sv ----
// self-checking bench for the humidity sensor command port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module hsi_cmd_port_tb_top;
    logic       clk_i = 1'b0, rst_b_i = 1'b0, res_valid_i = 1'b0, mem_fail_i = 1'b0;
    logic       cal_valid_i = 1'b0;
    logic [7:0] res_data_i = 8'h00, status_o, rd;
    logic       scl, host_oe, sda_o, sda_oe_o, conv_start_o, res_ready_o, ack;
    wire        sda = ~(host_oe | sda_oe_o);
    int         error_cnt = 0, samples_checked = 0, conv_cnt = 0;
    hsi_cmd_port #(.POR_CYC(50), .INIT_CYC(200), .FIFO_DEPTH(16)) dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(scl), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_start_o(conv_start_o),
        .res_valid_i(res_valid_i), .res_ready_o(res_ready_o), .res_data_i(res_data_i),
        .mem_fail_i(mem_fail_i), .cal_valid_i(cal_valid_i), .status_o(status_o));
    hsi_host_model host_u (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (conv_start_o === 1'b1) conv_cnt++;
    initial begin
        #200000 error_cnt++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr4(input logic [7:0] a, c, p0, p1);
        logic [31:0] f;
        f = {a, c, p0, p1};
        host_u.start();
        for (int i = 3; i >= 0; i--) begin
            host_u.put(f[i*8 +: 8], ack);
            `CHK(ack, (a == {hsi_pkg::DEV_ADDR, 1'b0}))
        end
        host_u.stop();
    endtask
    task automatic rd_n(input int n, input logic [7:0] e0);
        host_u.start();
        host_u.put({hsi_pkg::DEV_ADDR, 1'b1}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            host_u.get(i == n - 1, rd);
            `CHK(rd, (i == 0) ? e0 : 8'(8'h40 + i - 1))
        end
        host_u.stop();
    endtask
    // pushed inside an open frame so nothing drains while filling
    task automatic push16();
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_i);
            res_valid_i <= (i < 16);
            res_data_i <= 8'h40 + 8'(i);
            #1 `CHK(res_ready_o, i < 16)
        end
    endtask
    task automatic t_por();
        repeat (60) @(posedge clk_i);
        `CHK(status_o, 8'h00)
        `CHK(({scl, sda}), 2'h3)
        `CHK(sda_o, 1'b0)
        rd_n(1, 8'h00);
        `CHK(conv_cnt, 0)
    endtask
    task automatic t_init();
        wr4(8'h70, hsi_pkg::CMD_INIT, hsi_pkg::INIT_P0, hsi_pkg::PARAM_P1);
        `CHK(status_o[6:5], hsi_pkg::HSI_CMD)
        repeat (250) @(posedge clk_i);
        `CHK(status_o, 8'h08)
    endtask
    task automatic t_meas();
        @(posedge clk_i);
        mem_fail_i <= 1'b1;
        wr4(8'h72, hsi_pkg::CMD_TRIG, hsi_pkg::TRIG_P0, hsi_pkg::PARAM_P1);
        `CHK(conv_cnt, 0)
        wr4(8'h70, hsi_pkg::CMD_TRIG, hsi_pkg::TRIG_P0, hsi_pkg::PARAM_P1);
        `CHK(conv_cnt, 1)
        `CHK(status_o, 8'h98)
        rd_n(1, 8'h98);
        // second trigger while converting must be dropped
        wr4(8'h70, hsi_pkg::CMD_TRIG, hsi_pkg::TRIG_P0, hsi_pkg::PARAM_P1);
        `CHK(conv_cnt, 1)
        host_u.start();
        push16();
        host_u.stop();
        repeat (40) @(posedge clk_i);
        `CHK(status_o, 8'h18)
        rd_n(6, 8'h18);
        `CHK(conv_cnt, 1)
    endtask
    // mid-run reset with memory failure and calibration both present
    task automatic t_rst();
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        cal_valid_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK(status_o, 8'h00)
        rst_b_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        `CHK(status_o, 8'h18)
        rd_n(1, 8'h18);
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_por();
        t_init();
        t_meas();
        t_rst();
        stop_test();
    end
endmodule // hsi_cmd_port_tb_top
